/* File: include/rsmf_pkg.sv */
package rsmf_pkg;

    // =====================================================
    // register map (byte addresses, one 32-bit word each)
    // =====================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CORR_CFG = 8'h04;
    localparam logic [7:0] ADDR_RETX_LO = 8'h08;
    localparam logic [7:0] ADDR_RETX_HI = 8'h0c;
    localparam logic [7:0] ADDR_CFG_SUM = 8'h10;
    localparam logic [7:0] ADDR_STAT_MODE = 8'h14;
    localparam logic [7:0] ADDR_STAT_WEEK = 8'h18;
    localparam logic [7:0] ADDR_SAT_DESEL = 8'h1c;
    localparam logic [7:0] ADDR_CHAN_MASK = 8'h20;
    localparam logic [7:0] ADDR_TEST_A = 8'h24;
    localparam logic [7:0] ADDR_TEST_B = 8'h28;
    localparam logic [7:0] ADDR_TEST_C = 8'h2c;
    localparam logic [7:0] ADDR_BAUD_RATE = 8'h30;

    // =====================================================
    // control word fields
    // =====================================================
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_BUSY_BIT = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // =====================================================
    // message kinds and payload extents
    // =====================================================
    typedef enum logic [1:0] {
        MSG_CORR_CFG = 2'b00,
        MSG_IDENT = 2'b01,
        MSG_STATUS = 2'b10,
        MSG_SELF_TEST = 2'b11
    } rsmf_msg_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } rsmf_state_t;

    localparam logic [6:0] FIRST_BYTE = 7'h05;
    localparam logic [6:0] LAST_CORR_CFG = 7'h19;
    localparam logic [6:0] LAST_IDENT = 7'h63;
    localparam logic [6:0] LAST_STATUS = 7'h2c;
    localparam logic [6:0] LAST_SELF_TEST = 7'h28;

    // =====================================================
    // fixed masks that force reserved bits to zero
    // =====================================================
    localparam logic [7:0] MASK_CORR_FLAGS = 8'h81;
    localparam logic [7:0] MASK_STAT_B5 = 8'hf1;
    localparam logic [7:0] MASK_STAT_B6 = 8'hef;
    localparam logic [7:0] MASK_DISCRETE = 8'h3f;
    localparam logic [7:0] MASK_TEST_GEN = 8'h3f;
    localparam logic [7:0] MASK_TEST_MEM = 8'h1f;
    localparam logic [7:0] MASK_EEPROM = 8'h03;
    localparam logic [7:0] MASK_PORT = 8'h1f;
    localparam logic [7:0] MASK_RTC = 8'h0f;
    localparam logic [7:0] MASK_RF = 8'h3f;
    localparam logic [7:0] MASK_CHAN_HI = 8'h0f;

    // baud code is counted in steps of this many baud
    localparam logic [15:0] BAUD_UNIT = 16'h012c;

endpackage

/* File: verilog/rsmf_formatter.sv */
`timescale 1ns/1ps
// How it works
// - correction byte 5: bit 0 enable, bit 7 input port, 1-6 zero
// - correction byte 8 baud code counts steps of 300 baud
// - correction bytes 9-16 retransmit bitmap, bit 0 is message 1
// - identification bytes 33-36 carry first config block checksum
// - status byte 5 bit 0: 0 acquiring, 1 navigating
// - status byte 5 bits 4-5 power-up cause: normal, lock, watchdog
// - status byte 5 bit 6 tracking: all in view or sky search
// - status byte 5 bit 7 high while nonvolatile store is busy
// - status byte 6 bits 0,1 low when troposphere, sea-level models on
// - status byte 6 bits 2-3 last start: cold, warm, hot
// - status byte 6 bits 5-7 time source code 0 to 3
// - status bytes 11-14 satellite deselect map, satellite 1 first
// - status bytes 15-16 channel deselect map, channels 1 to 12
// - status bytes 24-25 mask angle, signed hundredths of degree
// - status byte 26 mirrors three inputs and three io pins
// - self-test byte 5 copies the request code
// - self-test byte 6 pass bits for six units in bits 0-5
// - self-test byte 10 checksum flags and flash code; nonzero locks
// - self-test bytes 12, 13 serial port fault flags in bits 0-4
// - self-test byte 14 clock chip faults in bits 0-3
// - self-test byte 15 rf faults, lock invalid in bit 5
// - self-test byte 18 channel 9-12 iq and measurement errors
module rsmf_formatter #(
    parameter int ADDR_W = 8,
    parameter logic [1:0] UNIT_TYPE = 2'h1 // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // live levels
    input wire logic discreteInputOne,
    input wire logic discreteInputTwo,
    input wire logic discreteInputThree,
    input wire logic discreteIoOne,
    input wire logic discreteIoTwo,
    input wire logic discreteIoThree,
    input wire logic nonvolatileStoreBusy,
    // payload byte stream
    output logic [7:0] txData,
    output logic txValid,
    output logic txFirst,
    output logic txLast,
    input wire logic txReady,
    // derived status
    output logic flashLocked
);

    // =====================================================
    // helpers
    // =====================================================
    function automatic logic [7:0] pickByte(input logic [63:0] v,
                                            input logic [2:0] sel);
        pickByte = v[{sel, 3'h0} +: 8];
    endfunction

    function automatic logic [6:0] lastOf(input rsmf_pkg::rsmf_msg_t m);
        unique case (m)
            rsmf_pkg::MSG_CORR_CFG: lastOf = rsmf_pkg::LAST_CORR_CFG;
            rsmf_pkg::MSG_IDENT: lastOf = rsmf_pkg::LAST_IDENT;
            rsmf_pkg::MSG_STATUS: lastOf = rsmf_pkg::LAST_STATUS;
            rsmf_pkg::MSG_SELF_TEST: lastOf = rsmf_pkg::LAST_SELF_TEST;
        endcase
    endfunction

    function automatic logic isAddr(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] off);
        isAddr = (a == ADDR_W'(off));
    endfunction

    // =====================================================
    // software registers
    // =====================================================
    logic [31:0] corrCfg_q;
    logic [63:0] retx_q;
    logic [31:0] cfgSum_q;
    logic [31:0] statMode_q;
    logic [31:0] statWeek_q;
    logic [31:0] satDesel_q;
    logic [31:0] chanMask_q;
    logic [31:0] testA_q;
    logic [31:0] testB_q;
    logic [31:0] testC_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            corrCfg_q <= rsmf_pkg::RESET_WORD;
            retx_q <= {rsmf_pkg::RESET_WORD, rsmf_pkg::RESET_WORD};
            cfgSum_q <= rsmf_pkg::RESET_WORD;
            statMode_q <= rsmf_pkg::RESET_WORD;
            statWeek_q <= rsmf_pkg::RESET_WORD;
            satDesel_q <= rsmf_pkg::RESET_WORD;
            chanMask_q <= rsmf_pkg::RESET_WORD;
            testA_q <= rsmf_pkg::RESET_WORD;
            testB_q <= rsmf_pkg::RESET_WORD;
            testC_q <= rsmf_pkg::RESET_WORD;
        end else if (regWr) begin
            if (isAddr(regAddr, rsmf_pkg::ADDR_CORR_CFG)) begin
                corrCfg_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_RETX_LO)) begin
                retx_q[31:0] <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_RETX_HI)) begin
                retx_q[63:32] <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_CFG_SUM)) begin
                cfgSum_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_STAT_MODE)) begin
                statMode_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_STAT_WEEK)) begin
                statWeek_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_SAT_DESEL)) begin
                satDesel_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_CHAN_MASK)) begin
                chanMask_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_TEST_A)) begin
                testA_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_TEST_B)) begin
                testB_q <= regWdata;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_TEST_C)) begin
                testC_q <= regWdata;
            end
        end
    end

    // =====================================================
    // discrete mirror
    // =====================================================
    logic [7:0] discretes;
    assign discretes = {2'h0, discreteIoThree, discreteIoTwo, discreteIoOne,
                        discreteInputThree, discreteInputTwo,
                        discreteInputOne};

    // =====================================================
    // sequencer state
    // =====================================================
    rsmf_pkg::rsmf_state_t state_q;
    rsmf_pkg::rsmf_msg_t msg_q;
    logic [6:0] idx_q;
    logic startReq;
    logic advance;
    rsmf_pkg::rsmf_msg_t selMsg;
    logic [6:0] nextIdx;
    logic [7:0] nextByte;

    // a start while a message is going out is ignored
    assign startReq = regWr && isAddr(regAddr, rsmf_pkg::ADDR_CTRL)
                      && regWdata[rsmf_pkg::CTRL_START_BIT]
                      && (state_q == rsmf_pkg::ST_IDLE);
    assign advance = (state_q == rsmf_pkg::ST_SEND) && txReady;
    assign selMsg = (state_q == rsmf_pkg::ST_IDLE)
                    ? rsmf_pkg::rsmf_msg_t'(regWdata[1:0]) : msg_q;
    assign nextIdx = (state_q == rsmf_pkg::ST_IDLE)
                     ? rsmf_pkg::FIRST_BYTE : idx_q + 7'h01;

    // =====================================================
    // payload byte composer
    // =====================================================
    // fields are read live, so a register rewritten mid-message
    // shows up in the bytes not yet loaded into txData
    always_comb begin
        nextByte = 8'h00;
        unique case (selMsg)
            rsmf_pkg::MSG_CORR_CFG: begin
                if (nextIdx == 7'h05) begin
                    nextByte = corrCfg_q[7:0] & rsmf_pkg::MASK_CORR_FLAGS;
                end else if (nextIdx == 7'h06) begin
                    nextByte = corrCfg_q[15:8];
                end else if (nextIdx == 7'h08) begin
                    nextByte = corrCfg_q[23:16];
                end else if (nextIdx >= 7'h09 && nextIdx <= 7'h10) begin
                    nextByte = pickByte(retx_q, 3'(nextIdx - 7'h09));
                end
            end
            rsmf_pkg::MSG_IDENT: begin
                if (nextIdx >= 7'h21 && nextIdx <= 7'h24) begin
                    nextByte = pickByte({32'h0000_0000, cfgSum_q},
                                        3'(nextIdx - 7'h21));
                end else if (nextIdx == 7'h63) begin
                    nextByte = {6'h00, UNIT_TYPE};
                end
            end
            rsmf_pkg::MSG_STATUS: begin
                if (nextIdx == 7'h05) begin
                    nextByte = {nonvolatileStoreBusy, statMode_q[6:0]}
                               & rsmf_pkg::MASK_STAT_B5;
                end else if (nextIdx == 7'h06) begin
                    nextByte = statMode_q[15:8] & rsmf_pkg::MASK_STAT_B6;
                end else if (nextIdx >= 7'h07 && nextIdx <= 7'h0a) begin
                    nextByte = pickByte({32'h0000_0000, statWeek_q},
                                        3'(nextIdx - 7'h07));
                end else if (nextIdx >= 7'h0b && nextIdx <= 7'h0e) begin
                    nextByte = pickByte({32'h0000_0000, satDesel_q},
                                        3'(nextIdx - 7'h0b));
                end else if (nextIdx == 7'h0f) begin
                    nextByte = chanMask_q[7:0];
                end else if (nextIdx == 7'h10) begin
                    nextByte = chanMask_q[15:8] & rsmf_pkg::MASK_CHAN_HI;
                end else if (nextIdx == 7'h18) begin
                    nextByte = chanMask_q[23:16];
                end else if (nextIdx == 7'h19) begin
                    nextByte = chanMask_q[31:24];
                end else if (nextIdx == 7'h1a) begin
                    nextByte = discretes & rsmf_pkg::MASK_DISCRETE;
                end
            end
            rsmf_pkg::MSG_SELF_TEST: begin
                if (nextIdx == 7'h05) begin
                    nextByte = testA_q[7:0];
                end else if (nextIdx == 7'h06) begin
                    nextByte = testA_q[15:8] & rsmf_pkg::MASK_TEST_GEN;
                end else if (nextIdx == 7'h0a) begin
                    nextByte = testA_q[23:16] & rsmf_pkg::MASK_TEST_MEM;
                end else if (nextIdx == 7'h0b) begin
                    nextByte = testA_q[31:24] & rsmf_pkg::MASK_EEPROM;
                end else if (nextIdx == 7'h0c) begin
                    nextByte = testB_q[7:0] & rsmf_pkg::MASK_PORT;
                end else if (nextIdx == 7'h0d) begin
                    nextByte = testB_q[15:8] & rsmf_pkg::MASK_PORT;
                end else if (nextIdx == 7'h0e) begin
                    nextByte = testB_q[23:16] & rsmf_pkg::MASK_RTC;
                end else if (nextIdx == 7'h0f) begin
                    nextByte = testB_q[31:24] & rsmf_pkg::MASK_RF;
                end else if (nextIdx >= 7'h10 && nextIdx <= 7'h12) begin
                    nextByte = pickByte({40'h00_0000_0000, testC_q[23:0]},
                                        3'(nextIdx - 7'h10));
                end
            end
        endcase
    end

    // =====================================================
    // stream sequencer
    // =====================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= rsmf_pkg::ST_IDLE;
            msg_q <= rsmf_pkg::MSG_CORR_CFG;
            idx_q <= rsmf_pkg::FIRST_BYTE;
            txData <= 8'h00;
            txValid <= 1'b0;
            txFirst <= 1'b0;
            txLast <= 1'b0;
        end else begin
            unique case (state_q)
                rsmf_pkg::ST_IDLE: begin
                    if (startReq) begin
                        state_q <= rsmf_pkg::ST_SEND;
                        msg_q <= selMsg;
                        idx_q <= nextIdx;
                        txData <= nextByte;
                        txValid <= 1'b1;
                        txFirst <= 1'b1;
                        txLast <= 1'b0;
                    end
                end
                rsmf_pkg::ST_SEND: begin
                    if (advance) begin
                        txFirst <= 1'b0;
                        if (idx_q == lastOf(msg_q)) begin
                            state_q <= rsmf_pkg::ST_IDLE;
                            txValid <= 1'b0;
                            txLast <= 1'b0;
                            txData <= 8'h00;
                        end else begin
                            idx_q <= nextIdx;
                            txData <= nextByte;
                            txLast <= (nextIdx == lastOf(msg_q));
                        end
                    end
                end
            endcase
        end
    end

    // =====================================================
    // flash lockout flag
    // =====================================================
    // nonzero flash code
    always_ff @(posedge mclk) begin
        if (rst) begin
            flashLocked <= 1'b0;
        end else begin
            flashLocked <= |testA_q[20:18];
        end
    end

    // =====================================================
    // register read-back
    // =====================================================
    // wide enough for the largest code, so no rate ever wraps
    logic [23:0] baudRate;
    assign baudRate = 24'(corrCfg_q[23:16]) * 24'(rsmf_pkg::BAUD_UNIT);

    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdata <= rsmf_pkg::RESET_WORD;
        end else if (regRd) begin
            regRdata <= rsmf_pkg::RESET_WORD;
            if (isAddr(regAddr, rsmf_pkg::ADDR_CTRL)) begin
                regRdata <= {16'h0000, 7'h00,
                             (state_q == rsmf_pkg::ST_SEND),
                             1'b0, idx_q[4:0] & 5'h00, msg_q};
                regRdata[22:16] <= idx_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_CORR_CFG)) begin
                regRdata <= corrCfg_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_RETX_LO)) begin
                regRdata <= retx_q[31:0];
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_RETX_HI)) begin
                regRdata <= retx_q[63:32];
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_CFG_SUM)) begin
                regRdata <= cfgSum_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_STAT_MODE)) begin
                regRdata <= {statMode_q[31:8], nonvolatileStoreBusy,
                             statMode_q[6:0]};
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_STAT_WEEK)) begin
                regRdata <= statWeek_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_SAT_DESEL)) begin
                regRdata <= satDesel_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_CHAN_MASK)) begin
                regRdata <= chanMask_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_TEST_A)) begin
                regRdata <= testA_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_TEST_B)) begin
                regRdata <= testB_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_TEST_C)) begin
                regRdata <= testC_q;
            end
            if (isAddr(regAddr, rsmf_pkg::ADDR_BAUD_RATE)) begin
                regRdata <= {8'h00, baudRate};
            end
        end else begin
            regRdata <= rsmf_pkg::RESET_WORD;
        end
    end

endmodule

/* File: bench/rsmf_formatter_assertions.sv */
`timescale 1ns/1ps
module rsmf_formatter_assertions #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // byte stream
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txFirst,
    input wire logic txLast,
    input wire logic txReady,
    input wire logic flashLocked
);
    // ====
    // message tracking
    // ====
    logic start;
    logic [1:0] msgQ;
    logic [6:0] cntQ;
    logic [6:0] lastIdx;
    // a start is only taken while no byte is offered
    assign start = regWr && regAddr == ADDR_W'(rsmf_pkg::ADDR_CTRL)
        && regWdata[8] && !txValid;
    assign lastIdx = msgQ == 2'h0 ? rsmf_pkg::LAST_CORR_CFG
        : msgQ == 2'h1 ? rsmf_pkg::LAST_IDENT
        : msgQ == 2'h2 ? rsmf_pkg::LAST_STATUS : rsmf_pkg::LAST_SELF_TEST;
    always_ff @(posedge mclk) begin
        if (rst || start) begin
            msgQ <= rst ? 2'h0 : regWdata[1:0];
            cntQ <= 7'h0;
        end else if (txValid && txReady) begin
            cntQ <= cntQ + 7'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ====
    // properties
    // ====
    rdata_idle_a: assert property (
        !regRd |=> regRdata == 32'h0) else $error("rdata not idle");
    byte_hold_a: assert property (
        txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
        else $error("byte not held");
    start_launch_a: assert property (
        start |=> txValid && txFirst) else $error("start lost");
    first_flag_a: assert property (
        txValid |-> txFirst == (cntQ == 7'h0)) else $error("first flag");
    msg_length_a: assert property (
        txValid |-> txLast == (cntQ == lastIdx - rsmf_pkg::FIRST_BYTE))
        else $error("message length");
    last_release_a: assert property (
        txValid && txReady && txLast |=> !txValid) else $error("no release");
    flash_lock_a: assert property (
        regWr && regAddr == ADDR_W'(rsmf_pkg::ADDR_TEST_A)
        |-> ##2 flashLocked == (|$past(regWdata[20:18], 2)))
        else $error("flash lock");
    corr_reserved_a: assert property (
        txValid && msgQ == 2'h0 && cntQ == 7'h0 |-> txData[6:1] == 6'h0)
        else $error("flag byte reserved");
    test_tail_a: assert property (
        txValid && msgQ == 2'h3 && cntQ > 7'hd |-> txData == 8'h00)
        else $error("self-test tail");
    disc_reserved_a: assert property (
        txValid && msgQ == 2'h2 && cntQ == 7'h15 |-> txData[7:6] == 2'h0)
        else $error("discrete reserved");
endmodule

bind rsmf_formatter rsmf_formatter_assertions #(.ADDR_W(ADDR_W)) chk (
    .mclk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .txData, .txValid, .txFirst, .txLast, .txReady, .flashLocked
);

/* File: bench/rsmf_host_sink.sv */
`timescale 1ns/1ps
module rsmf_host_sink (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // byte stream
    input wire logic txValid,
    output logic txReady,
    // pacing
    input wire logic slow
);
    // ====
    // acceptance pacing
    // ====
    // a slow host stalls at random so held bytes get exercised
    always_ff @(posedge mclk) begin
        if (rst) begin
            txReady <= 1'b0;
        end else begin
            txReady <= slow ? 1'($urandom_range(1)) : 1'b1;
        end
    end
endmodule

/* File: bench/rsmf_formatter_bench.sv */
`timescale 1ns/1ps
module rsmf_formatter_bench;
    // arbitrary unit type value
    localparam logic [1:0] UNIT_SEL = 2'h3;
    logic mclk;
    logic rst;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic regWr;
    logic regRd;
    logic [31:0] regRdata;
    logic [5:0] disc;
    logic nvBusy;
    logic [7:0] txData;
    logic txValid;
    logic txFirst;
    logic txLast;
    logic txReady;
    logic flashLocked;
    logic slow;
    logic rdPend = 1'b0;
    int fails = 0;
    int check_count = 0;
    logic [31:0] sh[16] = '{default: 32'h0};
    logic [31:0] rdQ[$];
    logic [7:0] byteQ[$];

    rsmf_formatter #(.UNIT_TYPE(UNIT_SEL)) uut (
        .mclk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .discreteInputOne(disc[0]), .discreteInputTwo(disc[1]),
        .discreteInputThree(disc[2]), .discreteIoOne(disc[3]),
        .discreteIoTwo(disc[4]), .discreteIoThree(disc[5]),
        .nonvolatileStoreBusy(nvBusy), .txData, .txValid, .txFirst,
        .txLast, .txReady, .flashLocked
    );
    rsmf_host_sink host (.mclk, .rst, .txValid, .txReady, .slow);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (e !== g) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [31:0] rdExp(int a);
        if (a == 5) return {sh[5][31:8], nvBusy, sh[5][6:0]};
        if (a == 12) return 32'(sh[1][23:16]) * 32'd300;
        return a < 12 ? sh[a] : 32'h0;
    endfunction

    function automatic logic [7:0] expByte(logic [1:0] m, int i);
        logic [63:0] rx;
        rx = {sh[3], sh[2]};
        if (m == 2'h0) begin
            if (i == 5) return sh[1][7:0] & 8'h81;
            if (i == 6) return sh[1][15:8];
            if (i == 8) return sh[1][23:16];
            if (i >= 9 && i <= 16) return rx[8*(i-9) +: 8];
        end else if (m == 2'h1) begin
            if (i >= 33 && i <= 36) return sh[4][8*(i-33) +: 8];
            if (i == 99) return {6'h0, UNIT_SEL};
        end else if (m == 2'h2) begin
            if (i == 5) return {nvBusy, sh[5][6:0]} & 8'hf1;
            if (i == 6) return sh[5][15:8] & 8'hef;
            if (i >= 7 && i <= 10) return sh[6][8*(i-7) +: 8];
            if (i >= 11 && i <= 14) return sh[7][8*(i-11) +: 8];
            if (i == 15) return sh[8][7:0];
            if (i == 16) return {4'h0, sh[8][11:8]};
            if (i == 24 || i == 25) return sh[8][8*(i-22) +: 8];
            if (i == 26) return {2'h0, disc};
        end else begin
            if (i == 5) return sh[9][7:0];
            if (i == 6) return sh[9][15:8] & 8'h3f;
            if (i == 10) return sh[9][23:16] & 8'h1f;
            if (i == 11) return {6'h0, sh[9][25:24]};
            if (i == 12 || i == 13) return sh[10][8*(i-12) +: 8] & 8'h1f;
            if (i == 14) return sh[10][23:16] & 8'h0f;
            if (i == 15) return sh[10][31:24] & 8'h3f;
            if (i >= 16 && i <= 18) return sh[11][8*(i-16) +: 8];
        end
        return 8'h00;
    endfunction

    // one bus cycle; strobes stay up if the next call asks again
    task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
        if (w && a[7:2] < 12) sh[a[7:2]] = d;
        if (r) rdQ.push_back(rdExp(int'(a[7:2])));
        @(posedge mclk);
    endtask

    task automatic send(logic [1:0] m, logic s);
        int last;
        last = m == 2'h0 ? 25 : m == 2'h1 ? 99 : m == 2'h2 ? 44 : 40;
        slow <= s;
        for (int i = 5; i <= last; i++) byteQ.push_back(expByte(m, i));
        bus(1'b1, 1'b0, 8'h00, {23'h0, 1'b1, 6'h0, m});
        // a second start while sending must be ignored
        bus(1'b1, 1'b0, 8'h00, {23'h0, 1'b1, 6'h0, m});
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        for (int n = 0; n < 2000 && (byteQ.size() > 0 || txValid); n++)
            @(posedge mclk);
        chk("bytes left", 32'h0, 32'(byteQ.size()));
        // idle control word: not busy, index parked on the last byte
        sh[0] = {9'h0, 7'(last), 7'h0, 1'b0, 6'h0, m};
        bus(1'b0, 1'b1, 8'h00, 32'h0);
    endtask

    // sampled mid-cycle so design updates have settled
    always @(negedge mclk) begin
        if (rdPend) chk("read data", rdQ.pop_front(), regRdata);
        rdPend = regRd && !rst;
        if (!rst && txValid && txReady) begin
            if (byteQ.size() == 0) chk("spare byte", 32'h0, 32'h1);
            else chk("byte", 32'(byteQ.pop_front()), 32'(txData));
        end
    end

    initial begin
        logic [31:0] d;
        static logic [7:0] bauds[3] = '{8'h01, 8'h20, 8'h40};
        rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        disc = 6'h0;
        nvBusy = 1'b0;
        slow = 1'b0;
        void'($urandom(51));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int a = 1; a <= 16; a++) bus(1'b0, 1'b1, 8'(4 * a), 32'h0);
        foreach (bauds[k]) begin
            bus(1'b1, 1'b0, rsmf_pkg::ADDR_CORR_CFG, {8'h0, bauds[k], 16'h0});
            bus(1'b0, 1'b1, rsmf_pkg::ADDR_BAUD_RATE, 32'h0);
        end
        for (int r = 0; r < 3; r++) begin
            disc <= 6'($urandom());
            nvBusy <= 1'($urandom());
            for (int a = 1; a <= 12; a++) begin
                d = $urandom();
                if (r == 0) d[20:18] = 3'h0;
                bus(1'b1, 1'b0, 8'(4 * a), d);
            end
            bus(1'b0, 1'b0, 8'h00, 32'h0);
            bus(1'b0, 1'b0, 8'h00, 32'h0);
            chk("flash lock", 32'(|sh[9][20:18]), 32'(flashLocked));
            for (int a = 1; a <= 12; a++) bus(1'b0, 1'b1, 8'(4 * a), 32'h0);
            for (int m = 0; m < 4; m++) send(2'(m), r[0]);
        end
        close_out();
    end

    initial begin
        repeat (50000) @(posedge mclk);
        fails++;
        close_out();
    end
endmodule
